// File: hw/plad_top.sv
/*
  plad_top: link and activity indicator driver for up to eight network ports.
  Drives on-card active-low bicolour link LEDs and activity LEDs and the
  matching active-low bits for the baseboard scan chain.
  Assumes all status inputs are synchronous to i_sys_clk (25 MHz), activity is
  a pulse or level from the controller, and the scan chain framing outside
  this block serialises o_scan_bits.
*/
// Contract
// RQ1 - each port's link LED is driven active low and a low level lights the selected green or amber colour.
// RQ2 - the link LED is lit steadily while the link is up, fault free and ready for packets.
// RQ3 - link colour is green at the highest speed, amber at a lower speed and dark with no link.
// RQ4 - with no amber LED fitted, green lights for an established link at any speed.
// RQ5 - on request the lit link LED blinks to identify the port.
// RQ6 - the green activity LED is active low and steadily on while the link is up and idle.
// RQ7 - with link up and traffic the activity LED blinks at a rate between one half and five hertz.
// RQ8 - each port places two link bits, one per colour, and one activity bit in the scan stream.
// RQ9 - the scan stream carries indications for at most eight ports.
// RQ10 - scan stream indicator bits are active low, zero meaning LED on.
// RQ11 - scan bits may replace or accompany the on-card LEDs, both showing the same state.
// RQ12 - activity is dark while the link is down and every indicator is dark during reset.
`timescale 1ns/1ps
module plad_top #(
  parameter int ACT_HALF_CYCLES = plad_pkg::ACT_HALF_CYC,
  parameter int ID_HALF_CYCLES  = plad_pkg::ID_HALF_CYC
) (
  input  wire logic                                             i_sys_clk,
  input  wire logic                                             i_rstn,
  input  wire plad_pkg::plad_port_in_t [plad_pkg::NUM_PORTS-1:0] i_ports,
  input  wire logic                                             i_amber_fitted,
  input  wire logic                                             i_local_en,
  input  wire logic                                             i_scan_en,
  output plad_pkg::plad_led_t [plad_pkg::NUM_PORTS-1:0]         o_leds,
  output logic [plad_pkg::SCAN_W-1:0]                           o_scan_bits
);

  localparam int NP = plad_pkg::NUM_PORTS;

  ////////////////////////////////////////////////////////////////////////////
  // strap capture: amber fitted is sampled once, after reset release

  plad_pkg::plad_cfg_st_t cfg_st_q;
  plad_pkg::plad_cfg_st_t cfg_st_d;
  logic                   amber_en_q;
  logic                   amber_en_d;

  always_comb begin
    cfg_st_d = cfg_st_q;
    amber_en_d = amber_en_q;
    case (cfg_st_q)
      plad_pkg::ST_RESET: begin
        amber_en_d = i_amber_fitted;
        cfg_st_d = plad_pkg::ST_RUN;
      end
      plad_pkg::ST_RUN: begin
        amber_en_d = amber_en_q;
      end
      default: begin
        cfg_st_d = plad_pkg::ST_RESET;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cfg_st_q <= plad_pkg::ST_RESET;
      amber_en_q <= plad_pkg::AMBER_CFG_RST;
    end else begin
      cfg_st_q <= cfg_st_d;
      amber_en_q <= amber_en_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // blink sources shared by all ports

  logic act_phase;
  logic act_tick;
  logic id_phase;
  logic id_tick;

  plad_blink #(
    .HALF_CYCLES (ACT_HALF_CYCLES)
  ) u_act_blink (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .o_phase   (act_phase),                                                  // [RQ7]
    .o_tick    (act_tick)
  );

  plad_blink #(
    .HALF_CYCLES (ID_HALF_CYCLES)
  ) u_id_blink (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .o_phase   (id_phase),                                                   // [RQ5]
    .o_tick    (id_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // activity stretch: traffic seen in one half period keeps blinking for the next

  logic [NP-1:0] act_in;
  logic [NP-1:0] link_on;
  logic [NP-1:0] seen_q;
  logic [NP-1:0] seen_d;
  logic [NP-1:0] busy_q;
  logic [NP-1:0] busy_d;

  always_comb begin
    for (int p = 0; p < NP; p++) begin
      act_in[p] = i_ports[p].activity;
      link_on[p] = i_ports[p].link_up & i_ports[p].fault_free & i_ports[p].ready;
    end
    seen_d = seen_q | act_in;
    busy_d = busy_q;
    if (act_tick) begin
      // new traffic on the boundary cycle still counts
      busy_d = seen_q | act_in;                                              // [RQ7]
      seen_d = '0;
    end
    seen_d = seen_d & link_on;                                               // [RQ12]
    busy_d = busy_d & link_on;                                               // [RQ12]
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      seen_q <= '0;
      busy_q <= '0;
    end else begin
      seen_q <= seen_d;
      busy_q <= busy_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-port decode and scan stream packing

  plad_pkg::plad_led_t [NP-1:0] scan_led;

  for (genvar p = 0; p < NP; p++) begin : g_port                             // [RQ9]
    plad_port u_port (
      .i_sys_clk   (i_sys_clk),
      .i_rstn      (i_rstn),
      .i_port      (i_ports[p]),
      .i_amber_en  (amber_en_q),
      .i_busy      (busy_q[p]),
      .i_act_phase (act_phase),
      .i_id_phase  (id_phase),
      .i_local_en  (i_local_en),                                             // [RQ11]
      .i_scan_en   (i_scan_en),                                              // [RQ11]
      .o_local     (o_leds[p]),
      .o_scan      (scan_led[p])
    );

    localparam int B = p * plad_pkg::SCAN_BITS_PER_PORT;
    assign o_scan_bits[B + plad_pkg::SCAN_POS_SPEED_A] = scan_led[p].green_n; // [RQ8]
    assign o_scan_bits[B + plad_pkg::SCAN_POS_SPEED_B] = scan_led[p].amber_n; // [RQ8]
    assign o_scan_bits[B + plad_pkg::SCAN_POS_ACT] = scan_led[p].act_n;       // [RQ8]
  end

  ////////////////////////////////////////////////////////////////////////////
  // check support: arming flop and blink half-period measure

  logic                       chk_arm_q;
  logic                       chk_arm_d;
  logic [plad_pkg::CNT_W-1:0] half_cnt_q;
  logic [plad_pkg::CNT_W-1:0] half_cnt_d;
  logic                       half_arm_q;
  logic                       half_arm_d;

  always_comb begin
    // no check starts on the edge that still sees reset
    chk_arm_d = 1'b1;
    half_cnt_d = half_cnt_q + 1'b1;
    half_arm_d = half_arm_q;
    if (act_tick) begin
      // count before the first tick is not a whole half period
      half_cnt_d = '0;
      half_arm_d = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      chk_arm_q <= 1'b0;
      half_cnt_q <= '0;
      half_arm_q <= 1'b0;
    end else begin
      chk_arm_q <= chk_arm_d;
      half_cnt_q <= half_cnt_d;
      half_arm_q <= half_arm_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rstn || !chk_arm_q);

  a_tick_spacing: assert property (act_tick |=> !act_tick [*8])  // [RQ7]
    else $error("activity blink ticks too close");

  a_busy_follow: assert property (act_tick && link_on[0] && (seen_q[0] || act_in[0]) |=> busy_q[0])  // [RQ7]
    else $error("traffic did not start activity blink");

  a_id_spacing: assert property (id_tick |=> !id_tick [*8])  // [RQ5]
    else $error("identify blink ticks too close");

  a_act_half: assert property (act_tick && half_arm_q |->  // [RQ7]
      half_cnt_q == plad_pkg::CNT_W'(ACT_HALF_CYCLES - 1))
    else $error("activity blink half period wrong length");

  a_act_late: assert property (half_arm_q |-> half_cnt_q < plad_pkg::CNT_W'(ACT_HALF_CYCLES))  // [RQ7]
    else $error("activity blink tick missing");

  a_strap_take: assert property (cfg_st_q == plad_pkg::ST_RESET |=>  // [RQ4]
      amber_en_q == $past(i_amber_fitted))
    else $error("amber strap not captured");

  a_strap_hold: assert property (cfg_st_q == plad_pkg::ST_RUN |=> $stable(amber_en_q))  // [RQ4]
    else $error("amber strap changed after capture");

  for (genvar p = 0; p < NP; p++) begin : g_chk
    sequence s_calm_link;
      link_on[p] && !i_ports[p].identify && i_scan_en;
    endsequence

    sequence s_busy_dark;
      link_on[p] && busy_q[p] && act_phase && i_scan_en;
    endsequence

    sequence s_calm_local;
      link_on[p] && !i_ports[p].identify && i_local_en;
    endsequence

    sequence s_traffic_tick;
      act_tick && link_on[p] && (seen_q[p] || act_in[p]);
    endsequence

    sequence s_quiet_tick;
      act_tick && link_on[p] && !seen_q[p] && !act_in[p];
    endsequence

    a_green_max: assert property (s_calm_link and i_ports[p].max_speed |=>  // [RQ3]
        !scan_led[p].green_n && scan_led[p].amber_n)
      else $error("green not shown at top speed");

    a_amber_low: assert property (s_calm_link and !i_ports[p].max_speed && amber_en_q |=>  // [RQ3]
        scan_led[p].green_n && !scan_led[p].amber_n)
      else $error("amber not shown at lower speed");

    a_green_only: assert property (s_calm_link and !amber_en_q |=>  // [RQ4]
        !scan_led[p].green_n && scan_led[p].amber_n)
      else $error("green not shown without amber");

    a_link_down: assert property (!link_on[p] |=>  // [RQ12]
        scan_led[p].green_n && scan_led[p].amber_n && scan_led[p].act_n)
      else $error("indicator lit with link down");

    a_act_solid: assert property (link_on[p] && !busy_q[p] && i_scan_en |=> !scan_led[p].act_n)  // [RQ6]
      else $error("idle activity not solid");

    a_act_blink: assert property (s_busy_dark |=> scan_led[p].act_n)  // [RQ7]
      else $error("activity not dark in blink phase");

    a_id_blink: assert property (link_on[p] && i_ports[p].identify && id_phase |=>  // [RQ5]
        scan_led[p].green_n && scan_led[p].amber_n)
      else $error("identify blink missing");

    a_paths_match: assert property (i_local_en && i_scan_en |=> o_leds[p] == scan_led[p])  // [RQ11]
      else $error("local and scan indicators differ");

    a_local_green: assert property (s_calm_local and i_ports[p].max_speed |=>  // [RQ1]
        !o_leds[p].green_n && o_leds[p].amber_n)
      else $error("local green not shown at top speed");

    a_local_amber: assert property (s_calm_local and !i_ports[p].max_speed && amber_en_q |=>  // [RQ1]
        o_leds[p].green_n && !o_leds[p].amber_n)
      else $error("local amber not shown at lower speed");

    a_local_act: assert property (link_on[p] && !busy_q[p] && i_local_en |=> !o_leds[p].act_n)  // [RQ6]
      else $error("local idle activity not solid");

    a_local_off: assert property (!i_local_en |=> o_leds[p] == plad_pkg::LEDS_OFF)  // [RQ11]
      else $error("local indicator lit while disabled");

    a_scan_off: assert property (!i_scan_en |=> scan_led[p] == plad_pkg::LEDS_OFF)  // [RQ11]
      else $error("scan indicator lit while disabled");

    a_busy_clear: assert property (!link_on[p] |=> !busy_q[p] && !seen_q[p])  // [RQ12]
      else $error("activity state kept with link down");

    a_busy_start: assert property (s_traffic_tick |=> busy_q[p])  // [RQ7]
      else $error("traffic did not start blinking");

    a_busy_quiet: assert property (s_quiet_tick |=> !busy_q[p])  // [RQ6]
      else $error("blinking kept without traffic");

    a_busy_steady: assert property (!act_tick && link_on[p] |=> $stable(busy_q[p]))  // [RQ7]
      else $error("blink state changed between ticks");
  end

endmodule

// File: include/plad_pkg.sv
/*
  plad_pkg: shared constants and carrier types for the port link and activity
  indicator driver.
  Assumes a 25 MHz logic clock and at most eight ports on the card.
*/
package plad_pkg;

  // geometry
  localparam int NUM_PORTS = 8;
  localparam int CNT_W = 24;

  // clock rate
  localparam int CLK_KHZ = 25000;

  // blink half periods, in milliseconds (activity 2 Hz, identify 1 Hz)
  localparam int ACT_HALF_MS = 250;
  localparam int ID_HALF_MS = 500;
  localparam int ACT_HALF_CYC = ACT_HALF_MS * CLK_KHZ;
  localparam int ID_HALF_CYC = ID_HALF_MS * CLK_KHZ;

  // scan bits per port and their positions inside a port's slice
  localparam int SCAN_BITS_PER_PORT = 3;
  localparam int SCAN_POS_SPEED_A = 0;
  localparam int SCAN_POS_SPEED_B = 1;
  localparam int SCAN_POS_ACT = 2;
  localparam int SCAN_W = NUM_PORTS * SCAN_BITS_PER_PORT;

  // reset values: every indicator dark (active low)
  localparam logic LED_OFF_N = 1'b1;
  localparam logic [SCAN_W-1:0] SCAN_RST = {SCAN_W{1'b1}};
  localparam logic AMBER_CFG_RST = 1'b1;

  // status from the network controller for one port
  typedef struct packed {
    logic link_up;
    logic fault_free;
    logic ready;
    logic max_speed;
    logic activity;
    logic identify;
  } plad_port_in_t;

  // active-low indicator drive for one port
  typedef struct packed {
    logic green_n;
    logic amber_n;
    logic act_n;
  } plad_led_t;

  localparam plad_led_t LEDS_OFF = '{green_n: 1'b1, amber_n: 1'b1, act_n: 1'b1};

  // start-up state of the strap capture
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_RUN   = 2'b01
  } plad_cfg_st_t;

endpackage

// File: hw/plad_blink.sv
/*
  plad_blink: free-running square wave with a one-cycle tick at each toggle.
  Assumes HALF_CYCLES fits in plad_pkg::CNT_W bits and is at least two.
*/
`timescale 1ns/1ps
module plad_blink #(
  parameter int HALF_CYCLES = plad_pkg::ACT_HALF_CYC
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rstn,
  output logic      o_phase,
  output logic      o_tick
);

  localparam logic [plad_pkg::CNT_W-1:0] LAST = plad_pkg::CNT_W'(HALF_CYCLES - 1);

  logic [plad_pkg::CNT_W-1:0] cnt_q;
  logic [plad_pkg::CNT_W-1:0] cnt_d;
  logic                       phase_q;
  logic                       phase_d;
  logic                       tick_q;
  logic                       tick_d;

  always_comb begin
    cnt_d = cnt_q + 1'b1;
    phase_d = phase_q;
    tick_d = 1'b0;
    if (cnt_q == LAST) begin
      cnt_d = '0;
      phase_d = ~phase_q;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_q <= '0;
      phase_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      phase_q <= phase_d;
      tick_q <= tick_d;
    end
  end

  assign o_phase = phase_q;
  assign o_tick = tick_q;

endmodule

// File: hw/plad_port.sv
/*
  plad_port: indicator decode for one port, registered local and scan drive.
  Assumes status inputs synchronous to i_sys_clk and blink phases from
  plad_blink.
*/
`timescale 1ns/1ps
module plad_port (
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_rstn,
  input  wire plad_pkg::plad_port_in_t i_port,
  input  wire logic                    i_amber_en,
  input  wire logic                    i_busy,
  input  wire logic                    i_act_phase,
  input  wire logic                    i_id_phase,
  input  wire logic                    i_local_en,
  input  wire logic                    i_scan_en,
  output plad_pkg::plad_led_t          o_local,
  output plad_pkg::plad_led_t          o_scan
);

  logic                link_on;
  logic                link_lit;
  logic                green_on;
  logic                amber_on;
  logic                act_on;
  plad_pkg::plad_led_t local_d;
  plad_pkg::plad_led_t local_q;
  plad_pkg::plad_led_t scan_d;
  plad_pkg::plad_led_t scan_q;

  always_comb begin
    link_on = i_port.link_up & i_port.fault_free & i_port.ready;            // [RQ2]
    link_lit = link_on & ~(i_port.identify & i_id_phase);                    // [RQ5]
    green_on = link_lit & (i_port.max_speed | ~i_amber_en);                  // [RQ3] [RQ4]
    amber_on = link_lit & ~i_port.max_speed & i_amber_en;                    // [RQ3]
    act_on = link_on & ~(i_busy & i_act_phase);                              // [RQ6] [RQ7] [RQ12]
    // low turns a colour on
    local_d.green_n = ~(green_on & i_local_en);                              // [RQ1]
    local_d.amber_n = ~(amber_on & i_local_en);                              // [RQ1]
    local_d.act_n = ~(act_on & i_local_en);                                  // [RQ6]
    scan_d.green_n = ~(green_on & i_scan_en);                                // [RQ8] [RQ10]
    scan_d.amber_n = ~(amber_on & i_scan_en);                                // [RQ8] [RQ10]
    scan_d.act_n = ~(act_on & i_scan_en);                                    // [RQ8] [RQ10]
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      local_q <= plad_pkg::LEDS_OFF;                                         // [RQ12]
      scan_q <= plad_pkg::LEDS_OFF;                                          // [RQ12]
    end else begin
      local_q <= local_d;
      scan_q <= scan_d;
    end
  end

  assign o_local = local_q;
  assign o_scan = scan_q;

endmodule

// File: sim/plad_scan_rx.sv
/*
  plad_scan_rx: model of the baseboard receiver that turns the indicator
  bits of the scan stream into remote LED drive.
  Assumes the scan bits arrive already deserialised, port 0 at the LSBs.
*/
`timescale 1ns/1ps
module plad_scan_rx (
  input  wire logic [plad_pkg::SCAN_W-1:0]    i_scan_bits,
  output logic      [plad_pkg::NUM_PORTS-1:0] o_green_on,
  output logic      [plad_pkg::NUM_PORTS-1:0] o_amber_on,
  output logic      [plad_pkg::NUM_PORTS-1:0] o_act_on
);
  ////////////////////////////////////////////////////////////////////////////
  // decode: a zero bit lights the remote LED, at most eight port entries
  always_comb begin
    for (int k = 0; k < plad_pkg::NUM_PORTS; k++) begin
      o_green_on[k] = ~i_scan_bits[3*k+plad_pkg::SCAN_POS_SPEED_A];
      o_amber_on[k] = ~i_scan_bits[3*k+plad_pkg::SCAN_POS_SPEED_B];
      o_act_on[k]   = ~i_scan_bits[3*k+plad_pkg::SCAN_POS_ACT];
    end
  end
endmodule

// File: sim/test_plad_top.sv
/*
  test_plad_top: self-checking bench for the indicator driver with the
  baseboard receiver model on the scan bits.
  Assumes short blink half periods so that blinking shows in a short run.
*/
`timescale 1ns/1ps
module test_plad_top;
  localparam int ACT_H = 20;
  localparam int ID_H  = 40;
  localparam int LIMIT = 6000;
  typedef plad_pkg::plad_port_in_t [7:0] ports_t;
  logic                      i_sys_clk = 1'b0;
  logic                      i_rstn    = 1'b0;
  ports_t                    ports     = '0;
  logic                      amber     = 1'b1;
  logic                      local_en  = 1'b1;
  logic                      scan_en   = 1'b1;
  plad_pkg::plad_led_t [7:0] leds;
  logic [23:0]               scan;
  logic [7:0]                r_green;
  logic [7:0]                r_amber;
  logic [7:0]                r_act;
  int                        miscompares = 0;
  int                        comparisons = 0;
  int                        cycles      = 0;

  always #20 i_sys_clk = ~i_sys_clk;

  plad_top #(.ACT_HALF_CYCLES(ACT_H), .ID_HALF_CYCLES(ID_H)) DUT (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_ports(ports), .i_amber_fitted(amber),
    .i_local_en(local_en), .i_scan_en(scan_en), .o_leds(leds), .o_scan_bits(scan));
  plad_scan_rx rx (.i_scan_bits(scan), .o_green_on(r_green), .o_amber_on(r_amber), .o_act_on(r_act));

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      wrap_up();
    end
  end

  function automatic ports_t base();
    ports_t p;
    for (int k = 0; k < 8; k++) p[k] = '{1'b1, k != 6, k != 7, k[0], 1'b0, 1'b0};
    return p;
  endfunction

  // expected scan bits, port k: green, amber, activity
  function automatic logic [23:0] exp_bits(input ports_t p, input logic amb);
    logic [23:0] s;
    logic        up;
    for (int k = 0; k < 8; k++) begin
      up = p[k].link_up & p[k].fault_free & p[k].ready;
      s[3*k+plad_pkg::SCAN_POS_SPEED_A] = ~(up & (p[k].max_speed | ~amb));
      s[3*k+plad_pkg::SCAN_POS_SPEED_B] = ~(up & ~p[k].max_speed & amb);
      s[3*k+plad_pkg::SCAN_POS_ACT]     = ~up;
    end
    return s;
  endfunction

  task automatic apply(input ports_t v);
    @(posedge i_sys_clk);
    ports <= v;
    @(posedge i_sys_clk);
    #1;
  endtask

  task automatic compare_all(input logic amb);
    logic [23:0] s;
    logic [23:0] l;
    s = exp_bits(ports, amb);
    for (int k = 0; k < 8; k++) l[3*k +: 3] = {s[3*k], s[3*k+1], s[3*k+2]};
    check("leds", leds, local_en ? l : 24'hFFFFFF);
    check("scan", scan, scan_en ? s : 24'hFFFFFF);
    check("remote", {r_green, r_amber, r_act}, {~s[21], ~s[18], ~s[15], ~s[12], ~s[9], ~s[6], ~s[3], ~s[0],
      ~s[22], ~s[19], ~s[16], ~s[13], ~s[10], ~s[7], ~s[4], ~s[1],
      ~s[23], ~s[20], ~s[17], ~s[14], ~s[11], ~s[8], ~s[5], ~s[2]} & {24{scan_en}});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic do_reset(input logic amb);
    @(posedge i_sys_clk);
    i_rstn <= 1'b0;
    amber  <= amb;
    ports  <= base();
    repeat (19) @(posedge i_sys_clk);
    #1;
    check("leds in reset", leds, 24'hFFFFFF);
    check("scan in reset", scan, 24'hFFFFFF);
    @(posedge i_sys_clk);
    i_rstn <= 1'b1;
  endtask

  task automatic t_colours();
    apply(base());
    for (int n = 0; n < 30; n++) begin
      compare_all(1'b1);
      @(posedge i_sys_clk);
      #1;
    end
  endtask

  task automatic t_activity();
    ports_t v;
    int     tog;
    int     diff;
    logic   last;
    v = base();
    v[0].activity = 1'b1;
    apply(v);
    tog  = 0;
    diff = 0;
    last = leds[0].act_n;
    for (int n = 0; n < 200; n++) begin
      @(posedge i_sys_clk);
      #1;
      if (leds[0].act_n !== last) tog++;
      if (scan[plad_pkg::SCAN_POS_ACT] !== leds[0].act_n) diff++;
      if ({leds[0].green_n, leds[0].amber_n} !== 2'b10) diff++;
      last = leds[0].act_n;
    end
    check("act toggles", tog >= 7 && tog <= 10, 1);
    check("act paths", diff, 0);
    check("act rate", plad_pkg::ACT_HALF_CYC * 2 >= plad_pkg::CLK_KHZ * 200 &&
      plad_pkg::ACT_HALF_CYC * 2 <= plad_pkg::CLK_KHZ * 2000, 1);
    v[0].link_up = 1'b0;
    apply(v);
    compare_all(1'b1);
  endtask

  task automatic t_identify();
    ports_t v;
    int     dark;
    v = base();
    v[1].identify = 1'b1;
    apply(v);
    dark = 0;
    for (int n = 0; n < 200; n++) begin
      @(posedge i_sys_clk);
      #1;
      if (leds[1].green_n === 1'b1) dark++;
    end
    check("ident dark", dark >= 80 && dark <= 120, 1);
    v[1].identify = 1'b0;
    apply(v);
    compare_all(1'b1);
  endtask

  task automatic t_no_amber();
    do_reset(1'b0);
    apply(base());
    compare_all(1'b0);
    @(posedge i_sys_clk);
    amber <= 1'b1;
    apply(base());
    compare_all(1'b0);
  endtask

  task automatic t_enables();
    @(posedge i_sys_clk);
    local_en <= 1'b0;
    apply(base());
    compare_all(1'b1);
    @(posedge i_sys_clk);
    local_en <= 1'b1;
    scan_en  <= 1'b0;
    apply(base());
    compare_all(1'b1);
    @(posedge i_sys_clk);
    scan_en <= 1'b1;
    apply(base());
    compare_all(1'b1);
  endtask

  initial begin
    do_reset(1'b1);
    t_colours();
    t_activity();
    t_identify();
    t_enables();
    t_no_amber();
    wrap_up();
  end
endmodule
